/* File: design/wut_timer.sv */
// Wake-up timer with slow clock select, duty-cycle, battery check and RC calibration
module wut_timer (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Slow clocks and calibration reference, sampled on clk
   input  wire logic        rc_clk_in,
   input  wire logic        xtal32_clk_in,
   input  wire logic        xo_ref_clk_in,
   input  wire logic        xo_ready,
   // Configuration
   input  wire logic        wake_timer_enable,
   input  wire logic        battery_check_enable,
   input  wire logic [1:0]  duty_cycle_mode_select,
   input  wire logic        rc_recal_enable,
   input  wire logic [2:0]  recal_interval_select,
   input  wire logic [2:0]  slow_clock_source_select,
   input  wire logic        timer_irq_enable,
   input  wire logic        chip_status_irq_enable,
   input  wire logic [5:0]  pin_function_code,
   input  wire logic [5:0]  irq_pin_function_code,
   // Property writes
   input  wire logic        prop_wr,
   input  wire logic [1:0]  prop_index,
   input  wire logic [7:0]  prop_data,
   // Chip events
   input  wire logic        sleep_entry,
   input  wire logic        power_on_cmd,
   input  wire logic        shutdown_exit,
   input  wire logic        irq_status_read,
   input  wire logic        packet_sent,
   input  wire logic [4:0]  battery_level,
   input  wire logic [4:0]  battery_threshold,
   // Outputs
   output logic             irq_out_n,
   output logic             gpio_out,
   output logic             wake_status,
   output logic             timer_running,
   output logic             go_ready,
   output logic             go_sleep,
   output logic             start_rx,
   output logic             start_tx,
   output logic             ldc_active,
   output logic             battery_measure,
   output logic             low_battery,
   output logic             xtal_osc_start,
   output logic             rc_cal_busy,
   output logic [6:0]       rc_trim
);

   // Stored properties
   logic [15:0]     period_mantissa;
   logic [4:0]      period_exponent;
   logic            post_expiry_sleep_select;
   logic [7:0]      duty_cycle_multiplier;

   // Counters and sequencer
   logic [33:0]     prescale;
   logic [15:0]     mant_cnt;
   logic [7:0]      ldc_cnt;
   logic [17:0]     recal_cnt;
   logic [5:0]      cal_rc_cnt;
   logic [15:0]     cal_ref_cnt;
   logic            cal_req;
   wut_pkg::wut_cal_e cal_state;
   wut_pkg::wut_cal_e next_cal_state;

   // Edge pulses
   logic            rc_rise;
   logic            xt_rise;
   logic            ref_rise;

   wut_edge u_rc_edge (
      .clk     (clk),
      .sys_rst (sys_rst),
      .level   (rc_clk_in),
      .rise    (rc_rise)
   );

   wut_edge u_xt_edge (
      .clk     (clk),
      .sys_rst (sys_rst),
      .level   (xtal32_clk_in),
      .rise    (xt_rise)
   );

   wut_edge u_ref_edge (
      .clk     (clk),
      .sys_rst (sys_rst),
      .level   (xo_ref_clk_in),
      .rise    (ref_rise)
   );

   // Property write decode
   wire wr_mant_high = prop_wr & (prop_index == wut_pkg::PROP_MANT_HIGH);
   wire wr_mant_low  = prop_wr & (prop_index == wut_pkg::PROP_MANT_LOW);
   wire wr_exponent  = prop_wr & (prop_index == wut_pkg::PROP_EXPONENT);
   wire wr_ldc_mult  = prop_wr & (prop_index == wut_pkg::PROP_LDC_MULT);

   // Slow tick source selection
   wire sel_rc    = (slow_clock_source_select == wut_pkg::SLOW_SRC_RC);
   wire sel_xt    = (slow_clock_source_select == wut_pkg::SLOW_SRC_XTAL);
   wire slow_tick = (sel_rc & rc_rise) | (sel_xt & xt_rise);

   // Mantissa unit of 4 * 2^exponent slow ticks
   wire [33:0] unit_term  = (wut_pkg::UNIT_BASE << period_exponent) - 34'h1;
   wire        unit_end   = (prescale == unit_term);
   wire        unit_tick  = timer_running & slow_tick & unit_end;
   wire [33:0] prescale_p = prescale + 34'h1;

   // Period expiry after mantissa units
   wire [15:0] mant_next  = mant_cnt + 16'h1;
   wire        mant_nz    = (period_mantissa != 16'h0000);
   wire        mant_wrap  = (mant_next == period_mantissa);
   wire        expire     = unit_tick & mant_nz & mant_wrap;

   // Duty-cycle mode decode and window end
   wire        mode_off   = (duty_cycle_mode_select == wut_pkg::LDC_OFF);
   wire        mode_rx    = (duty_cycle_mode_select == wut_pkg::LDC_RX);
   wire        mode_tx    = (duty_cycle_mode_select == wut_pkg::LDC_TX);
   wire [7:0]  ldc_next   = ldc_cnt + 8'h01;
   wire        ldc_win    = unit_tick & (ldc_next >= duty_cycle_multiplier);
   wire        ldc_end    = ldc_active & ~expire & (ldc_win | (mode_tx & packet_sent));
   wire        ret_post   = (expire & mode_off) | ldc_end;

   // Interrupt routing
   wire        irq_timer  = wake_status & timer_irq_enable & chip_status_irq_enable;
   wire        irq_pin_wk = (irq_pin_function_code == wut_pkg::IRQ_CODE_WAKE) & wake_status;
   wire        pin_wk     = (pin_function_code == wut_pkg::PIN_CODE_WAKE) & wake_status;

   // Periodic recalibration interval
   wire [17:0] recal_span = wut_pkg::RECAL_ONE << (5'(wut_pkg::RECAL_BASE_SHIFT) + 5'(recal_interval_select));
   wire        recal_due  = rc_recal_enable & rc_rise & (recal_cnt == recal_span - 18'h1);
   wire        cal_trig   = power_on_cmd | shutdown_exit | recal_due;

   // Calibration measurement end and comparison
   wire        meas_done  = rc_rise & (cal_rc_cnt == wut_pkg::CAL_TICKS - 6'h01);
   wire        rc_slow    = (cal_ref_cnt > wut_pkg::CAL_REF_COUNT);
   wire        rc_fast    = (cal_ref_cnt < wut_pkg::CAL_REF_COUNT);

   // Property storage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         period_mantissa          <= wut_pkg::MANTISSA_RESET;
         period_exponent          <= wut_pkg::EXPONENT_RESET;
         post_expiry_sleep_select <= 1'b0;
         duty_cycle_multiplier    <= wut_pkg::LDC_MULT_RESET;
      end else begin
         if (wr_mant_high) period_mantissa[15:8] <= prop_data;
         if (wr_mant_low)  period_mantissa[7:0]  <= prop_data;
         if (wr_exponent) begin
            period_exponent          <= prop_data[wut_pkg::EXP_MSB:wut_pkg::EXP_LSB];
            post_expiry_sleep_select <= prop_data[wut_pkg::SLEEP_SEL_BIT];
         end
         if (wr_ldc_mult)  duty_cycle_multiplier <= prop_data;
      end
   end

   // Arm on sleep entry while enabled, stay armed for repeated wakes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_running <= 1'b0;
      end else if (!wake_timer_enable) begin
         timer_running <= 1'b0;
      end else if (sleep_entry) begin
         timer_running <= 1'b1;
      end
   end

   // Prescaler over slow ticks
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prescale <= 34'h0;
      end else if (!timer_running) begin
         prescale <= 34'h0;
      end else if (slow_tick) begin
         prescale <= unit_end ? 34'h0 : prescale_p;
      end
   end

   // Mantissa counter, restarting each period
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mant_cnt <= 16'h0000;
      end else if (!timer_running) begin
         mant_cnt <= 16'h0000;
      end else if (unit_tick) begin
         mant_cnt <= mant_wrap ? 16'h0000 : mant_next;
      end
   end

   // Expiry flag; a new expiry wins over the status read
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wake_status <= 1'b0;
      end else if (expire) begin
         wake_status <= 1'b1;
      end else if (irq_status_read) begin
         wake_status <= 1'b0;
      end
   end

   // Interrupt and pin outputs, active low interrupt
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_out_n <= 1'b1;
         gpio_out  <= 1'b0;
      end else begin
         irq_out_n <= ~(irq_timer | irq_pin_wk);
         gpio_out  <= pin_wk;
      end
   end

   // Duty-cycle window tracking
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ldc_active <= 1'b0;
         ldc_cnt    <= 8'h00;
      end else if (expire & ~mode_off) begin
         ldc_active <= 1'b1;
         ldc_cnt    <= 8'h00;
      end else if (ldc_end | mode_off | ~timer_running) begin
         ldc_active <= 1'b0;
         ldc_cnt    <= 8'h00;
      end else if (ldc_active & unit_tick) begin
         ldc_cnt    <= ldc_next;
      end
   end

   // Wake actions, one-cycle pulses
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         go_ready        <= 1'b0;
         go_sleep        <= 1'b0;
         start_rx        <= 1'b0;
         start_tx        <= 1'b0;
         battery_measure <= 1'b0;
      end else begin
         go_ready        <= ret_post & ~post_expiry_sleep_select;
         go_sleep        <= ret_post & post_expiry_sleep_select;
         start_rx        <= expire & mode_rx;
         start_tx        <= expire & mode_tx;
         battery_measure <= expire & battery_check_enable;
      end
   end

   // Low battery comparison at each expiry while the battery check is enabled
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         low_battery <= 1'b0;
      end else if (expire & battery_check_enable) begin
         low_battery <= (battery_level < battery_threshold);
      end
   end

   // Recalibration interval counter on RC ticks
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         recal_cnt <= 18'h0;
      end else if (!rc_recal_enable | recal_due) begin
         recal_cnt <= 18'h0;
      end else if (rc_rise) begin
         recal_cnt <= recal_cnt + 18'h1;
      end
   end

   // Pending calibration request; a trigger wins over the take
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cal_req <= 1'b0;
      end else if (cal_trig) begin
         cal_req <= 1'b1;
      end else if (cal_state == wut_pkg::WUT_CAL_IDLE) begin
         cal_req <= 1'b0;
      end
   end

   // Calibration sequencer next state
   always_comb begin
      next_cal_state = cal_state;
      case (cal_state)
         wut_pkg::WUT_CAL_IDLE: begin
            if (cal_req) next_cal_state = wut_pkg::WUT_CAL_XO;
         end
         wut_pkg::WUT_CAL_XO: begin
            if (xo_ready) next_cal_state = wut_pkg::WUT_CAL_MEAS;
         end
         wut_pkg::WUT_CAL_MEAS: begin
            if (meas_done) next_cal_state = wut_pkg::WUT_CAL_ADJ;
         end
         wut_pkg::WUT_CAL_ADJ: begin
            next_cal_state = wut_pkg::WUT_CAL_IDLE;
         end
         default: begin
            next_cal_state = wut_pkg::WUT_CAL_IDLE;
         end
      endcase
   end

   // Sequencer state and status outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cal_state      <= wut_pkg::WUT_CAL_IDLE;
         xtal_osc_start <= 1'b0;
         rc_cal_busy    <= 1'b0;
      end else begin
         cal_state      <= next_cal_state;
         xtal_osc_start <= (next_cal_state != wut_pkg::WUT_CAL_IDLE);
         rc_cal_busy    <= (next_cal_state != wut_pkg::WUT_CAL_IDLE);
      end
   end

   // Count reference edges over a fixed number of RC ticks
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cal_rc_cnt  <= 6'h00;
         cal_ref_cnt <= 16'h0000;
      end else if (cal_state != wut_pkg::WUT_CAL_MEAS) begin
         cal_rc_cnt  <= 6'h00;
         cal_ref_cnt <= 16'h0000;
      end else begin
         if (rc_rise)  cal_rc_cnt  <= cal_rc_cnt + 6'h01;
         if (ref_rise) cal_ref_cnt <= cal_ref_cnt + 16'h0001;
      end
   end

   // Trim step toward the reference, saturating at the ends
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rc_trim <= wut_pkg::RC_TRIM_RESET;
      end else if (cal_state == wut_pkg::WUT_CAL_ADJ) begin
         if (rc_slow && rc_trim != 7'h7F) rc_trim <= rc_trim + 7'h01;
         else if (rc_fast && rc_trim != 7'h00) rc_trim <= rc_trim - 7'h01;
      end
   end

endmodule : wut_timer

/* File: inc/wut_pkg.sv */
// Constants, encodings and types shared by the wake-up timer design
package wut_pkg;

   // Property indices on the property write port
   localparam logic [1:0] PROP_MANT_HIGH = 2'h0;
   localparam logic [1:0] PROP_MANT_LOW  = 2'h1;
   localparam logic [1:0] PROP_EXPONENT  = 2'h2;
   localparam logic [1:0] PROP_LDC_MULT  = 2'h3;

   // Field positions inside the exponent property
   localparam int EXP_LSB       = 0;
   localparam int EXP_MSB       = 4;
   localparam int SLEEP_SEL_BIT = 5;

   // Reset values of the properties and of the RC trim
   localparam logic [15:0] MANTISSA_RESET = 16'h0001;
   localparam logic [4:0]  EXPONENT_RESET = 5'h00;
   localparam logic [7:0]  LDC_MULT_RESET = 8'h00;
   localparam logic [6:0]  RC_TRIM_RESET  = 7'h40;

   // Slow clock source codes
   localparam logic [2:0] SLOW_SRC_NONE = 3'h0;
   localparam logic [2:0] SLOW_SRC_RC   = 3'h1;
   localparam logic [2:0] SLOW_SRC_XTAL = 3'h2;

   // Duty-cycle mode codes
   localparam logic [1:0] LDC_OFF = 2'h0;
   localparam logic [1:0] LDC_RX  = 2'h1;
   localparam logic [1:0] LDC_TX  = 2'h2;

   // Pin function codes that carry the expiry indication
   localparam logic [5:0] PIN_CODE_WAKE = 6'h0E;
   localparam logic [5:0] IRQ_CODE_WAKE = 6'h27;

   // Timebase: each mantissa unit spans 4 * 2^exponent slow ticks
   localparam logic [33:0] UNIT_BASE = 34'h4;

   // Calibration: reference count over a fixed number of RC ticks
   localparam int          RC_HZ         = 32768;
   localparam int          XO_HZ         = 30000000;
   localparam int          CAL_RC_TICKS  = 32;
   localparam logic [5:0]  CAL_TICKS     = 6'(CAL_RC_TICKS);
   localparam logic [15:0] CAL_REF_COUNT = 16'((XO_HZ / RC_HZ) * CAL_RC_TICKS
                                               + ((XO_HZ % RC_HZ) * CAL_RC_TICKS + RC_HZ / 2) / RC_HZ);

   // Periodic recalibration: interval is 2^(base + select) RC ticks
   localparam int          RECAL_BASE_SHIFT = 10;
   localparam logic [17:0] RECAL_ONE        = 18'h1;

   // Calibration sequencer states, Gray along the path
   typedef enum logic [1:0] {
      WUT_CAL_IDLE = 2'b00,
      WUT_CAL_XO   = 2'b01,
      WUT_CAL_MEAS = 2'b11,
      WUT_CAL_ADJ  = 2'b10
   } wut_cal_e;

endpackage : wut_pkg

/* File: design/wut_edge.sv */
// Rising-edge detector for a slow clock sampled on the system clock
module wut_edge (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic level,
   output logic      rise
);

   logic level_q;

   // Previous sample of the level
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_q <= 1'b0;
      end else begin
         level_q <= level;
      end
   end

   // One-cycle pulse on a low-to-high change
   assign rise = level & ~level_q;

endmodule : wut_edge

/* File: tb/wut_timer_monitor.sv */
// Port checker for the wake-up timer
module wut_timer_monitor (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       wake_timer_enable,
   input wire logic       battery_check_enable,
   input wire logic [1:0] duty_cycle_mode_select,
   input wire logic       timer_irq_enable,
   input wire logic       chip_status_irq_enable,
   input wire logic [5:0] pin_function_code,
   input wire logic [5:0] irq_pin_function_code,
   input wire logic       sleep_entry,
   input wire logic       power_on_cmd,
   input wire logic       irq_status_read,
   input wire logic [4:0] battery_level,
   input wire logic [4:0] battery_threshold,
   input wire logic       irq_out_n,
   input wire logic       gpio_out,
   input wire logic       wake_status,
   input wire logic       timer_running,
   input wire logic       go_ready,
   input wire logic       go_sleep,
   input wire logic       start_rx,
   input wire logic       start_tx,
   input wire logic       ldc_active,
   input wire logic       battery_measure,
   input wire logic       low_battery,
   input wire logic       rc_cal_busy,
   input wire logic       xtal_osc_start
);
   timeunit 1ns;
   timeprecision 1ps;
   // All checks on the system clock
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   arm_runs_a: assert property (sleep_entry && wake_timer_enable |=> timer_running)
      else $error("timer not running after arming");
   irq_low_a: assert property (wake_status && timer_irq_enable && chip_status_irq_enable |=> !irq_out_n)
      else $error("expiry not signalled on irq");
   irq_gated_a: assert property (!(timer_irq_enable && chip_status_irq_enable)
      && irq_pin_function_code != wut_pkg::IRQ_CODE_WAKE |=> irq_out_n) else $error("irq without enable");
   pin_follows_a: assert property (pin_function_code == wut_pkg::PIN_CODE_WAKE |=> gpio_out == $past(wake_status))
      else $error("pin does not show expiry");
   irq_code_a: assert property (irq_pin_function_code == wut_pkg::IRQ_CODE_WAKE
      && wake_status |=> !irq_out_n) else $error("expiry not on irq pin");
   return_pulse_a: assert property ($rose(wake_status) && duty_cycle_mode_select == wut_pkg::LDC_OFF
      |-> $onehot({go_ready, go_sleep})) else $error("no return pulse");
   rx_start_a: assert property ($rose(wake_status) && duty_cycle_mode_select == wut_pkg::LDC_RX
      |-> start_rx && !start_tx && ldc_active) else $error("rx not started");
   tx_start_a: assert property ($rose(wake_status) && duty_cycle_mode_select == wut_pkg::LDC_TX
      |-> start_tx && !start_rx && ldc_active) else $error("tx not started");
   batt_measure_a: assert property ($rose(wake_status) |-> battery_measure == battery_check_enable)
      else $error("battery measure wrong");
   batt_compare_a: assert property (battery_measure |-> low_battery == (battery_level < battery_threshold))
      else $error("battery compare wrong");
   status_clear_a: assert property (wake_status && irq_status_read |=> !wake_status)
      else $error("status not cleared");
   cal_start_a: assert property (power_on_cmd && !rc_cal_busy |-> ##2 rc_cal_busy && xtal_osc_start)
      else $error("calibration not started");
endmodule : wut_timer_monitor

/* File: tb/wut_host_model.sv */
// Host model that confirms timer interrupts by reading the status
module wut_host_model (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic irq_out_n,
   input  wire logic wake_status,
   input  wire logic ack_all,
   output logic      irq_status_read
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_cnt;
   // Status read a few cycles after the request is seen
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_cnt        <= 2'h0;
         irq_status_read <= 1'b0;
      end else begin
         irq_status_read <= 1'b0;
         wait_cnt        <= 2'h0;
         if (!irq_out_n || (ack_all && wake_status)) begin
            wait_cnt        <= wait_cnt + 2'h1;
            irq_status_read <= (wait_cnt == 2'h3);
         end
      end
   end
endmodule : wut_host_model

/* File: tb/test_wake_up_timer.sv */
// Self-checking bench for the wake-up timer
module test_wake_up_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, sys_rst = 1'b1, rc_clk_in = 1'b0, xtal32_clk_in = 1'b0, xo_ref_clk_in = 1'b0;
   logic        xo_ready = 1'b0, wake_timer_enable = 1'b0, battery_check_enable = 1'b0, rc_recal_enable = 1'b0;
   logic [1:0]  duty_cycle_mode_select = 2'h0, prop_index = 2'h0;
   logic [2:0]  slow_clock_source_select = 3'h1, recal_interval_select = 3'h0;
   logic        timer_irq_enable = 1'b1, chip_status_irq_enable = 1'b1, prop_wr = 1'b0, sleep_entry = 1'b0;
   logic [5:0]  pin_function_code = 6'h0E, irq_pin_function_code = 6'h00;
   logic [7:0]  prop_data = 8'h00;
   logic        power_on_cmd = 1'b0, shutdown_exit = 1'b0, packet_sent = 1'b0, ack_all = 1'b0;
   logic [4:0]  battery_level = 5'h03, battery_threshold = 5'h05;
   logic        irq_status_read, irq_out_n, gpio_out, wake_status, timer_running, go_ready, go_sleep;
   logic        start_rx, start_tx, ldc_active, battery_measure, low_battery, xtal_osc_start, rc_cal_busy;
   logic [6:0]  rc_trim;
   logic [31:0] cyc = 32'h0;
   int          sleeps = 0;
   int          rc_rises = 0, mark = 0, n, mismatches = 0, total_checks = 0;

   wut_timer dut (.clk, .sys_rst, .rc_clk_in, .xtal32_clk_in, .xo_ref_clk_in, .xo_ready, .wake_timer_enable,
      .battery_check_enable, .duty_cycle_mode_select, .rc_recal_enable, .recal_interval_select,
      .slow_clock_source_select, .timer_irq_enable, .chip_status_irq_enable, .pin_function_code,
      .irq_pin_function_code, .prop_wr, .prop_index, .prop_data, .sleep_entry, .power_on_cmd, .shutdown_exit,
      .irq_status_read, .packet_sent, .battery_level, .battery_threshold, .irq_out_n, .gpio_out, .wake_status,
      .timer_running, .go_ready, .go_sleep, .start_rx, .start_tx, .ldc_active, .battery_measure, .low_battery,
      .xtal_osc_start, .rc_cal_busy, .rc_trim);
   wut_host_model host (.clk, .sys_rst, .irq_out_n, .wake_status, .ack_all, .irq_status_read);

   // System clock
   initial forever #4 clk = ~clk;
   // Slow clocks sped up to keep the run short
   always @(posedge clk) begin
      cyc           <= cyc + 32'h1;
      rc_clk_in     <= cyc[2];
      xtal32_clk_in <= (cyc % 10) >= 5;
      xo_ref_clk_in <= cyc[1];
      if (cyc[2:0] == 3'h4) rc_rises <= rc_rises + 1;
      if (go_sleep) sleeps <= sleeps + 1;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic prop(input logic [1:0] idx, input logic [7:0] data);
      @(posedge clk);
      prop_wr    <= 1'b1;
      prop_index <= idx;
      prop_data  <= data;
      @(posedge clk);
      prop_wr <= 1'b0;
   endtask : prop

   // Arm just after a slow tick falls, so no rise is in flight
   task automatic arm();
      @(posedge clk iff cyc[2:0] == 3'h0);
      sleep_entry <= 1'b1;
      @(posedge clk);
      mark = rc_rises;
      sleep_entry <= 1'b0;
   endtask : arm

   // Waits for the next expiry; n is RC rises since the last mark, or -1
   task automatic wait_wake(input int lim);
      logic prev;
      prev = 1'b1;
      n = -1;
      for (int i = 0; i < lim && n < 0; i++) begin
         @(posedge clk);
         if (wake_status === 1'b1 && prev === 1'b0) n = rc_rises - mark;
         prev = wake_status;
      end
      if (n >= 0) mark = rc_rises;
   endtask : wait_wake

   task automatic wait_busy(input logic lvl, input int lim);
      for (int i = 0; i < lim && rc_cal_busy !== lvl; i++) @(posedge clk);
   endtask : wait_busy

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      chk(irq_out_n, 1, "irq idle");
      chk(rc_trim, 8'h40, "trim reset");
      chk(timer_running, 0, "idle");
      $display("reset test done");
      prop(wut_pkg::PROP_MANT_HIGH, 8'h00);
      prop(wut_pkg::PROP_MANT_LOW, 8'h02);
      prop(wut_pkg::PROP_EXPONENT, 8'h01);
      wake_timer_enable <= 1'b1;
      arm();
      wait_wake(400);
      chk(8'(n), 8'(2 * 4 * 2), "period ticks");
      chk(go_ready, 1, "ready return");
      repeat (2) @(posedge clk);
      chk(irq_out_n, 0, "irq on expiry");
      chk(gpio_out, 1, "pin on expiry");
      repeat (8) @(posedge clk);
      chk(wake_status, 0, "flag cleared");
      chk(irq_out_n, 1, "irq released");
      wait_wake(400);
      chk(8'(n), 8'(2 * 4 * 2), "repeat period");
      $display("period test done");
      chip_status_irq_enable <= 1'b0;
      ack_all                <= 1'b1;
      wait_wake(400);
      repeat (2) @(posedge clk);
      chk(irq_out_n, 1, "group gate");
      prop(wut_pkg::PROP_EXPONENT, 8'h21);
      prop(wut_pkg::PROP_LDC_MULT, 8'h01);
      for (int m = 1; m <= 2; m++) begin
         duty_cycle_mode_select <= 2'(m);
         wait_wake(400);
         chk(start_rx, 8'(m == 1), "rx start");
         chk(start_tx, 8'(m == 2), "tx start");
      end
      n = sleeps;
      packet_sent <= 1'b1;
      @(posedge clk);
      packet_sent <= 1'b0;
      repeat (3) @(posedge clk);
      chk(8'(sleeps - n), 1, "sleep return");
      chk(ldc_active, 0, "tx window end");
      duty_cycle_mode_select <= wut_pkg::LDC_RX;
      wait_wake(400);
      repeat (40) @(posedge clk);
      chk(ldc_active, 1, "rx window open");
      repeat (40) @(posedge clk);
      chk(ldc_active, 0, "rx window end");
      $display("duty cycle test done");
      duty_cycle_mode_select <= wut_pkg::LDC_OFF;
      battery_check_enable   <= 1'b1;
      chip_status_irq_enable <= 1'b1;
      timer_irq_enable       <= 1'b0;
      wait_wake(400);
      chk(battery_measure, 1, "battery measure");
      chk(low_battery, 1, "battery low");
      chk(go_sleep, 1, "sleep return");
      repeat (2) @(posedge clk);
      chk(irq_out_n, 1, "timer irq gate");
      battery_level         <= 5'h09;
      irq_pin_function_code <= wut_pkg::IRQ_CODE_WAKE;
      wait_wake(400);
      chk(low_battery, 0, "battery fine");
      repeat (2) @(posedge clk);
      chk(irq_out_n, 0, "irq code path");
      slow_clock_source_select <= wut_pkg::SLOW_SRC_NONE;
      wait_wake(400);
      chk(8'(n), 8'hFF, "no source");
      slow_clock_source_select <= wut_pkg::SLOW_SRC_XTAL;
      wait_wake(600);
      chk(8'(n >= 0), 1, "crystal source");
      $display("source test done");
      power_on_cmd <= 1'b1;
      @(posedge clk);
      power_on_cmd <= 1'b0;
      repeat (20) @(posedge clk);
      chk(xtal_osc_start, 1, "xtal started");
      chk(rc_cal_busy, 1, "cal waits");
      xo_ready <= 1'b1;
      wait_busy(1'b0, 1000);
      chk(rc_trim, 8'h3F, "trim down");
      rc_recal_enable <= 1'b1;
      wait_busy(1'b1, 9000);
      chk(rc_cal_busy, 1, "recal due");
      wait_busy(1'b0, 1000);
      chk(rc_trim, 8'h3E, "recal trim");
      shutdown_exit <= 1'b1;
      @(posedge clk);
      shutdown_exit <= 1'b0;
      wait_busy(1'b1, 10);
      chk(rc_cal_busy, 1, "shutdown cal");
      wait_busy(1'b0, 1000);
      chk(rc_trim, 8'h3D, "shutdown trim");
      wake_timer_enable <= 1'b0;
      repeat (2) @(posedge clk);
      chk(timer_running, 0, "disarm");
      $display("calibration test done");
      conclude();
   end

   // Watchdog
   initial begin
      #(30000 * 8);
      mismatches++;
      conclude();
   end
endmodule : test_wake_up_timer

bind wut_timer wut_timer_monitor mon (.clk, .sys_rst, .wake_timer_enable, .battery_check_enable,
   .duty_cycle_mode_select, .timer_irq_enable, .chip_status_irq_enable, .pin_function_code,
   .irq_pin_function_code, .sleep_entry, .power_on_cmd, .irq_status_read, .battery_level, .battery_threshold,
   .irq_out_n, .gpio_out, .wake_status, .timer_running, .go_ready, .go_sleep, .start_rx, .start_tx, .ldc_active,
   .battery_measure, .low_battery, .rc_cal_busy, .xtal_osc_start);
